/* File: hw/vcr_pkg.sv */
// vcr_pkg: constants and carriers for the video core control register bank.
// assumes 16-bit registers at 12-bit word addresses of the host port.
package vcr_pkg;

    // register word addresses
    localparam logic [11:0] ADDR_RASTER_S1   = 12'h833;
    localparam logic [11:0] ADDR_FLYWHEEL    = 12'h834;
    localparam logic [11:0] ADDR_RATE_MODE   = 12'h835;
    localparam logic [11:0] ADDR_TIM_FORMAT  = 12'h836;
    localparam logic [11:0] ADDR_TIM_CFG     = 12'h837;
    localparam logic [11:0] ADDR_MASK_S1_LAT = 12'h848;
    localparam logic [11:0] ADDR_MASK_S1_LIV = 12'h849;
    localparam logic [11:0] ADDR_MASK_S2     = 12'h84A;
    localparam logic [11:0] ADDR_AUDIO_CLOCK_GEN_CTRL    = 12'h84B;
    localparam logic [11:0] ADDR_INPUT_ROUTE = 12'h84D;
    localparam logic [11:0] ADDR_CARRIER_SRC = 12'h868;
    localparam logic [11:0] ADDR_PLL_STAT    = 12'h86B;
    localparam logic [11:0] ADDR_PLL_STICKY  = 12'h86C;
    localparam logic [11:0] ADDR_SIGNAL_LOSS_CTRL    = 12'h86F;
    localparam logic [11:0] ADDR_CLK_DELAY   = 12'h870;
    localparam logic [11:0] ADDR_CLK_INVERT  = 12'h871;

    // rate_mode_select fields
    localparam int RM_PROC_EN = 4;
    localparam int RM_ASI_EN  = 3;
    localparam int RM_AUTO    = 2;
    localparam logic [4:0] RST_RATE_MODE = 5'h14;

    // line rate codes
    localparam logic [1:0] RATE_HD = 2'h0;
    localparam logic [1:0] RATE_3G = 2'h2;

    // carrier source codes
    localparam logic [1:0] CD_EDGE   = 2'h0;
    localparam logic [1:0] CD_ANALOG = 2'h1;
    localparam logic [1:0] CD_AND    = 2'h2;

    // other reset values
    localparam logic [1:0] RST_ROUTE      = 2'h3;
    localparam logic [1:0] RST_CD_SEL     = 2'h2;
    localparam logic [8:0] RST_SIGNAL_LOSS_CTRL   = 9'h155;
    localparam int         SIGNAL_SENSE_INPUT_SEL_BIT    = 8;

    // sticky bit positions within pll_sticky_status[6:4]
    localparam int STK_LOCK  = 2;
    localparam int STK_PHASE = 1;
    localparam int STK_LOS   = 0;

    // status from the receive logic, same clock
    typedef struct packed {
        logic        rateDivisorFlag;
        logic        standardLocked;
        logic        scanType;
        logic [10:0] activeLines;
        logic        flywheelVertLocked;
        logic        flywheelHorizLocked;
        logic        compliantLock;
        logic [1:0]  detectedRate;
        logic [5:0]  timingFormatCode;
        logic        formatErr;
        logic        edgeCarrierFiltered;
        logic        analogCarrierFiltered;
        logic        recoveryRefIsData;
        logic        recoveryLockedRaw;
        logic        analogPhaseLocked;
        logic        digitalPhaseLocked;
        logic        deviceLocked;
    } vcr_status_s;

    // controls toward the receive logic
    typedef struct packed {
        logic        processingEnable;
        logic        asiActive;
        logic        rateDetectAuto;
        logic [1:0]  lineRate;
        logic        vsyncInvert;
        logic        hsyncInvert;
        logic [9:0]  errMaskS1Latched;
        logic [9:0]  errMaskS1Live;
        logic [13:0] errMaskS2;
        logic        audioFreeRun;
        logic        audioBitclkInvert;
        logic        audioMasterclkInvert;
        logic [1:0]  audioMasterclkRatio;
        logic        parallelInSel;
        logic        loopThroughSel;
        logic        carrierDetect;
        logic        signalSenseInputSel;
        logic [3:0]  losTuning;
        logic [4:0]  outclkDelay;
        logic        outclkInvert;
    } vcr_ctrl_s;

endpackage : vcr_pkg

/* File: hw/vcr_ctrl_regs.sv */
// vcr_ctrl_regs: control and status registers of the video core.
// assumes the host port is already deserialised into word strobes on clk.
// Summary of operation
// - raster status bit 13 shows frame divisor 1.001 when set, 1 when clear.
// - flywheel status bit 1 is vertical lock, bit 0 horizontal lock.
// - in automatic mode processing enable reads one once locked to compliant video.
// - in manual mode software writes processing enable to turn processing on or off.
// - ASI extraction only in manual mode, processing enable low, ASI bit high.
// - rate detect mode bit: zero manual, one automatic; resets automatic.
// - manual rate field: 00 HD, 01/11 SD, 10 3G; resets 00.
// - read-only six-bit timing format code plus error flag that resets high.
// - ten-bit mask for stream one sticky error sources.
// - ten-bit mask for stream one non-sticky error sources, same layout.
// - fourteen-bit stream two mask: 13:7 non-sticky, 6:0 sticky.
// - audio PLL free-run bit: zero acquires reference, one free-runs.
// - invert bits for audio bit clock and audio master clock.
// - master clock ratio field: 00 128fs, 01 256fs, 10 512fs.
// - route field: low bit picks parallel input, high bit loop-through; resets 3.
// - carrier source: edge, analog, AND, OR; resets to 2.
// - loss of signal reads inverse of carrier detect, plus raw PLL status bits.
// - read-only bit shows recovery reference is data (1) or clock (0).
// - sticky flags for lost lock, lost phase lock, lost signal; cleared by writing one.
// - signal sense input select: zero first input, one second; resets one.
// - five-bit output clock delay per rate, picked by the active rate.
// - output clock invert per rate, one bit each for SD, HD and 3G.
`timescale 1ns/1ps

module vcr_ctrl_regs
    import vcr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] hostAddr,
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    input  wire logic [15:0] hostWdata,
    output logic      [15:0] hostRdata,
    output logic             hostRvalid,
    input  wire vcr_status_s statusIn,
    output vcr_ctrl_s        ctrlOut
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [4:0]  rateMode;
        logic [1:0]  syncInv;
        logic [9:0]  maskS1Lat;
        logic [9:0]  maskS1Liv;
        logic [13:0] maskS2;
        logic [5:0]  acg;
        logic [1:0]  route;
        logic [1:0]  cdSel;
        logic [2:0]  sticky;
        logic [8:0]  losCtrl;
        logic [14:0] delay;
        logic [2:0]  invert;
        vcr_status_s stat;
        vcr_ctrl_s   ctl;
        logic [15:0] rdata;
        logic        rvalid;
    } vcr_state_s;

    vcr_state_s state_r;
    vcr_state_s state_nxt;

    assign hostRdata  = state_r.rdata;
    assign hostRvalid = state_r.rvalid;
    assign ctrlOut    = state_r.ctl;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic        isAuto;
        logic        procEn;
        logic [1:0]  rate;
        logic        cd;
        logic [15:0] rd;
        isAuto = 1'b0;
        procEn = 1'b0;
        rate   = 2'h0;
        cd     = 1'b0;
        rd     = 16'h0000;

        state_nxt      = state_r;
        state_nxt.stat = statusIn;

        // register writes, reserved bits dropped
        if (hostWrite) begin
            case (hostAddr)
                ADDR_RATE_MODE:   state_nxt.rateMode  = hostWdata[4:0];
                ADDR_TIM_CFG:     state_nxt.syncInv   = hostWdata[2:1];
                ADDR_MASK_S1_LAT: state_nxt.maskS1Lat = hostWdata[9:0];
                ADDR_MASK_S1_LIV: state_nxt.maskS1Liv = hostWdata[9:0];
                ADDR_MASK_S2:     state_nxt.maskS2    = hostWdata[13:0];
                ADDR_AUDIO_CLOCK_GEN_CTRL:    state_nxt.acg       = {hostWdata[5:3], 1'b0, hostWdata[1:0]};
                ADDR_INPUT_ROUTE: state_nxt.route     = hostWdata[3:2];
                ADDR_CARRIER_SRC: state_nxt.cdSel     = hostWdata[1:0];
                ADDR_SIGNAL_LOSS_CTRL:    state_nxt.losCtrl   = hostWdata[8:0];
                ADDR_CLK_DELAY:   state_nxt.delay     = hostWdata[14:0];
                ADDR_CLK_INVERT:  state_nxt.invert    = hostWdata[2:0];
                ADDR_PLL_STICKY:  state_nxt.sticky    = state_r.sticky & ~hostWdata[6:4];
                default: ;
            endcase
        end

        // carrier detect from the selected detector(s)
        case (state_r.cdSel)
            CD_EDGE:   cd = state_r.stat.edgeCarrierFiltered;
            CD_ANALOG: cd = state_r.stat.analogCarrierFiltered;
            CD_AND:    cd = state_r.stat.edgeCarrierFiltered & state_r.stat.analogCarrierFiltered;
            default:   cd = state_r.stat.edgeCarrierFiltered | state_r.stat.analogCarrierFiltered;
        endcase

        // set wins over a same-cycle clear
        if (!state_r.stat.deviceLocked)
            state_nxt.sticky[STK_LOCK] = 1'b1;
        if (!state_r.stat.digitalPhaseLocked)
            state_nxt.sticky[STK_PHASE] = 1'b1;
        if (!cd)
            state_nxt.sticky[STK_LOS] = 1'b1;

        // mode resolution
        isAuto = state_r.rateMode[RM_AUTO];
        procEn = isAuto ? state_r.stat.compliantLock
                        : state_r.rateMode[RM_PROC_EN];
        rate   = isAuto ? state_r.stat.detectedRate : state_r.rateMode[1:0];

        state_nxt.ctl.processingEnable     = procEn;
        state_nxt.ctl.asiActive            = !isAuto && !procEn && state_r.rateMode[RM_ASI_EN];
        state_nxt.ctl.rateDetectAuto       = isAuto;
        state_nxt.ctl.lineRate             = rate;
        state_nxt.ctl.vsyncInvert          = state_r.syncInv[1];
        state_nxt.ctl.hsyncInvert          = state_r.syncInv[0];
        state_nxt.ctl.errMaskS1Latched     = state_r.maskS1Lat;
        state_nxt.ctl.errMaskS1Live        = state_r.maskS1Liv;
        state_nxt.ctl.errMaskS2            = state_r.maskS2;
        state_nxt.ctl.audioFreeRun         = state_r.acg[5];
        state_nxt.ctl.audioBitclkInvert    = state_r.acg[4];
        state_nxt.ctl.audioMasterclkInvert = state_r.acg[3];
        state_nxt.ctl.audioMasterclkRatio  = state_r.acg[1:0];
        state_nxt.ctl.parallelInSel        = state_r.route[0];
        state_nxt.ctl.loopThroughSel       = state_r.route[1];
        state_nxt.ctl.carrierDetect        = cd;
        state_nxt.ctl.signalSenseInputSel  = state_r.losCtrl[SIGNAL_SENSE_INPUT_SEL_BIT];
        state_nxt.ctl.losTuning            = state_r.losCtrl[7:4];

        // delay and invert follow the rate in use
        case (rate)
            RATE_HD: begin
                state_nxt.ctl.outclkDelay  = state_r.delay[9:5];
                state_nxt.ctl.outclkInvert = state_r.invert[1];
            end
            RATE_3G: begin
                state_nxt.ctl.outclkDelay  = state_r.delay[4:0];
                state_nxt.ctl.outclkInvert = state_r.invert[0];
            end
            default: begin
                state_nxt.ctl.outclkDelay  = state_r.delay[14:10];
                state_nxt.ctl.outclkInvert = state_r.invert[2];
            end
        endcase

        // read mux; unmapped and reserved return zero
        case (hostAddr)
            ADDR_RASTER_S1:   rd = {2'h0, state_r.stat.rateDivisorFlag,
                                    state_r.stat.standardLocked, state_r.stat.scanType,
                                    state_r.stat.activeLines};
            ADDR_FLYWHEEL:    rd = {14'h0000, state_r.stat.flywheelVertLocked,
                                    state_r.stat.flywheelHorizLocked};
            ADDR_RATE_MODE:   rd = {11'h000, procEn, state_r.rateMode[3:0]};
            ADDR_TIM_FORMAT:  rd = {9'h000, state_r.stat.formatErr,
                                    state_r.stat.timingFormatCode};
            ADDR_TIM_CFG:     rd = {13'h0000, state_r.syncInv, 1'b0};
            ADDR_MASK_S1_LAT: rd = {6'h00, state_r.maskS1Lat};
            ADDR_MASK_S1_LIV: rd = {6'h00, state_r.maskS1Liv};
            ADDR_MASK_S2:     rd = {2'h0, state_r.maskS2};
            ADDR_AUDIO_CLOCK_GEN_CTRL:    rd = {10'h000, state_r.acg};
            ADDR_INPUT_ROUTE: rd = {12'h000, state_r.route, 2'h0};
            ADDR_CARRIER_SRC: rd = {14'h0000, state_r.cdSel};
            ADDR_PLL_STAT:    rd = {6'h00, state_r.stat.recoveryRefIsData,
                                    state_r.stat.recoveryLockedRaw, ~cd,
                                    state_r.stat.analogPhaseLocked,
                                    state_r.stat.digitalPhaseLocked, cd,
                                    state_r.stat.edgeCarrierFiltered,
                                    state_r.stat.analogCarrierFiltered, 2'h0};
            ADDR_PLL_STICKY:  rd = {9'h000, state_r.sticky, 4'h0};
            ADDR_SIGNAL_LOSS_CTRL:    rd = {7'h00, state_r.losCtrl};
            ADDR_CLK_DELAY:   rd = {1'b0, state_r.delay};
            ADDR_CLK_INVERT:  rd = {13'h0000, state_r.invert};
            default:          rd = 16'h0000;
        endcase
        state_nxt.rdata  = hostRead ? rd : state_r.rdata;
        state_nxt.rvalid = hostRead;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r                          <= '0;
            state_r.rateMode                 <= RST_RATE_MODE;
            state_r.route                    <= RST_ROUTE;
            state_r.cdSel                    <= RST_CD_SEL;
            state_r.losCtrl                  <= RST_SIGNAL_LOSS_CTRL;
            state_r.stat.formatErr           <= 1'b1;
            state_r.stat.edgeCarrierFiltered <= 1'b1;
            state_r.stat.deviceLocked        <= 1'b1;
            state_r.stat.digitalPhaseLocked  <= 1'b1;
            state_r.ctl.processingEnable     <= 1'b1;
            state_r.ctl.rateDetectAuto       <= 1'b1;
            state_r.ctl.parallelInSel        <= 1'b1;
            state_r.ctl.loopThroughSel       <= 1'b1;
            state_r.ctl.signalSenseInputSel  <= 1'b1;
            state_r.ctl.losTuning            <= 4'h5;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule : vcr_ctrl_regs

/* File: tb/vcr_rx_model.sv */
// vcr_rx_model: stand-in for the receive logic that feeds status.
// assumes the bench sets the wanted status; it lands one edge later.
`timescale 1ns/1ps

module vcr_rx_model
    import vcr_pkg::*;
(
    input  wire logic  clk,
    input  vcr_status_s want,
    output vcr_status_s statusOut
);
    // real status leaves registered logic, so it lags one edge
    always_ff @(posedge clk) begin
        statusOut <= want;
    end
endmodule : vcr_rx_model

/* File: tb/vcr_ctrl_regs_asserts.sv */
// vcr_ctrl_regs_asserts: port-level checks of the register bank.
// assumes it is bound into vcr_ctrl_regs, one clock domain.
`timescale 1ns/1ps

module vcr_ctrl_regs_asserts
    import vcr_pkg::*;
(
    input logic        clk,
    input logic        rst_n,
    input logic [11:0] hostAddr,
    input logic        hostWrite,
    input logic        hostRead,
    input logic [15:0] hostWdata,
    input logic [15:0] hostRdata,
    input logic        hostRvalid,
    input vcr_status_s statusIn,
    input vcr_ctrl_s   ctrlOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    property p_unmapped;
        hostRead && hostAddr == 12'h84C |=> hostRvalid && hostRdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mode;
        hostWrite && hostAddr == ADDR_RATE_MODE |-> ##2 ctrlOut.rateDetectAuto == $past(hostWdata[2], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("rate detect mode wrong");
    property p_man;
        hostWrite && hostAddr == ADDR_RATE_MODE && !hostWdata[2] |-> ##2 ctrlOut.lineRate == $past(hostWdata[1:0], 2);
    endproperty
    a_man: assert property (p_man) else $error("manual line rate wrong");
    property p_autope;
        // status snapshot is still at reset two edges after release, so skip those edges
        $past(rst_n, 2) && $past(ctrlOut.rateDetectAuto) && ctrlOut.rateDetectAuto
            |-> ctrlOut.processingEnable == $past(statusIn.compliantLock, 2);
    endproperty
    a_autope: assert property (p_autope) else $error("auto processing enable wrong");
    property p_asi;
        hostWrite && hostAddr == ADDR_RATE_MODE |-> ##2 ctrlOut.asiActive == ($past(hostWdata[4:2], 2) == 3'b010);
    endproperty
    a_asi: assert property (p_asi) else $error("asi enable wrong");
    property p_mask;
        hostWrite && hostAddr == ADDR_MASK_S2 |-> ##2 ctrlOut.errMaskS2 == $past(hostWdata[13:0], 2);
    endproperty
    a_mask: assert property (p_mask) else $error("stream two mask wrong");
    property p_route;
        hostWrite && hostAddr == ADDR_INPUT_ROUTE |-> ##2
            {ctrlOut.loopThroughSel, ctrlOut.parallelInSel} == $past(hostWdata[3:2], 2);
    endproperty
    a_route: assert property (p_route) else $error("input route wrong");
    property p_cd;
        $past(rst_n, 2) && $past(statusIn.edgeCarrierFiltered, 2) == $past(statusIn.analogCarrierFiltered, 2)
            |-> ctrlOut.carrierDetect == $past(statusIn.edgeCarrierFiltered, 2);
    endproperty
    a_cd: assert property (p_cd) else $error("carrier detect wrong");
    property p_los;
        hostRead && hostAddr == ADDR_PLL_STAT |=> hostRdata[7] != hostRdata[4] && hostRdata[1:0] == 2'h0;
    endproperty
    a_los: assert property (p_los) else $error("loss of signal not inverse");
    property p_stk;
        hostRead && hostAddr == ADDR_PLL_STICKY && !$past(statusIn.deviceLocked, 2) |=> hostRdata[6];
    endproperty
    a_stk: assert property (p_stk) else $error("lost lock not latched");
endmodule : vcr_ctrl_regs_asserts

bind vcr_ctrl_regs vcr_ctrl_regs_asserts u_vcr_ctrl_regs_asserts (.clk, .rst_n, .hostAddr, .hostWrite,
    .hostRead, .hostWdata, .hostRdata, .hostRvalid, .statusIn, .ctrlOut);

/* File: tb/testbench.sv */
// testbench: drives the register bank through its word strobes.
// assumes vcr_rx_model supplies status and the checker is bound in.
`timescale 1ns/1ps

module testbench
    import vcr_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic [11:0] hostAddr;
    logic        hostWrite;
    logic        hostRead;
    logic [15:0] hostWdata;
    logic [15:0] hostRdata;
    logic        hostRvalid;
    vcr_status_s st;
    vcr_status_s statusIn;
    vcr_ctrl_s   ctrlOut;
    int          num_errors;
    int          total_checks;
    // address, writable bits, reset value of each read-write register
    logic [11:0] rA [11] = '{12'h835, 12'h837, 12'h848, 12'h849, 12'h84A, 12'h84B,
                             12'h84D, 12'h868, 12'h86F, 12'h870, 12'h871};
    logic [15:0] rM [11] = '{16'h001F, 16'h0006, 16'h03FF, 16'h03FF, 16'h3FFF, 16'h003B,
                             16'h000C, 16'h0003, 16'h01FF, 16'h7FFF, 16'h0007};
    logic [15:0] rR [11] = '{16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h000C, 16'h0002, 16'h0155, 16'h0000, 16'h0000};
    logic [7:0]  rateE [4] = '{8'h14, 8'h63, 8'h87, 8'hE3};
    logic [15:0] asiW [3] = '{16'h0008, 16'h0018, 16'h000C};
    logic [1:0]  asiE [3] = '{2'h2, 2'h1, 2'h1};
    logic [3:0]  cdE = 4'b1001;

    vcr_rx_model u_vcr_rx_model (.clk(clk), .want(st), .statusOut(statusIn));
    vcr_ctrl_regs u_vcr_ctrl_regs (.clk, .rst_n, .hostAddr, .hostWrite, .hostRead, .hostWdata,
        .hostRdata, .hostRvalid, .statusIn, .ctrlOut);
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        hostAddr  <= a;
        hostWdata <= d;
        hostWrite <= 1'b1;
        @(posedge clk);
        hostWrite <= 1'b0;
        @(posedge clk);
    endtask : wr
    // answer is fixed at one cycle, so no longer wait is needed
    task automatic rc(input logic [11:0] a, input logic [15:0] e);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge clk);
        hostRead <= 1'b0;
        @(posedge clk);
        chk({15'h0000, hostRvalid}, 16'h0001);
        chk(hostRdata, e);
    endtask : rc
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        hostAddr = 12'h000;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        hostWdata = 16'h0000;
        st = '0;
        st.compliantLock = 1'b1;
        st.edgeCarrierFiltered = 1'b1;
        st.deviceLocked = 1'b1;
        st.digitalPhaseLocked = 1'b1;
        st.formatErr = 1'b1;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 11; i++) rc(rA[i], rR[i]);
        rc(12'h836, 16'h0040);
        for (int i = 0; i < 11; i++) begin
            wr(rA[i], 16'hFFFF);
            rc(rA[i], rM[i]);
            wr(rA[i], 16'h0000);
            rc(rA[i], 16'h0000);
        end
        wr(12'h834, 16'hFFFF);
        rc(12'h834, 16'h0000);
        rc(12'h84C, 16'h0000);
        chk(16'(ctrlOut.signalSenseInputSel), 16'h0000);
        wr(12'h837, 16'h0004);
        wr(12'h848, 16'h02A5);
        wr(12'h849, 16'h015A);
        wr(12'h86F, 16'h00A0);
        settle();
        chk(16'({ctrlOut.vsyncInvert, ctrlOut.hsyncInvert}), 16'h0002);
        chk(16'(ctrlOut.errMaskS1Latched), 16'h02A5);
        chk(16'(ctrlOut.errMaskS1Live), 16'h015A);
        chk(16'(ctrlOut.losTuning), 16'h000A);
        chk(16'(ctrlOut.signalSenseInputSel), 16'h0000);
        for (int r = 0; r < 3; r++) begin
            wr(12'h84B, 16'h0028 + 16'(r));
            settle();
            chk(16'({ctrlOut.audioFreeRun, ctrlOut.audioBitclkInvert, ctrlOut.audioMasterclkInvert,
                ctrlOut.audioMasterclkRatio}), 16'h0014 + 16'(r));
        end
        wr(12'h870, 16'h4543);
        wr(12'h871, 16'h0005);
        for (int r = 0; r < 4; r++) begin
            wr(12'h835, 16'(r));
            settle();
            chk(16'({ctrlOut.lineRate, ctrlOut.outclkDelay, ctrlOut.outclkInvert}), 16'(rateE[r]));
        end
        for (int i = 0; i < 3; i++) begin
            wr(12'h835, asiW[i]);
            settle();
            chk(16'({ctrlOut.asiActive, ctrlOut.processingEnable}), 16'(asiE[i]));
        end
        st.rateDivisorFlag <= 1'b1;
        st.standardLocked <= 1'b1;
        st.activeLines <= 11'h438;
        st.flywheelVertLocked <= 1'b1;
        st.timingFormatCode <= 6'h10;
        st.formatErr <= 1'b0;
        st.recoveryRefIsData <= 1'b1;
        st.analogPhaseLocked <= 1'b1;
        st.analogCarrierFiltered <= 1'b1;
        wr(12'h868, 16'h0000);
        settle();
        rc(12'h833, 16'h3438);
        rc(12'h834, 16'h0002);
        rc(12'h836, 16'h0010);
        rc(12'h86B, 16'h027C);
        st.analogCarrierFiltered <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr(12'h868, 16'(s));
            settle();
            rc(12'h86B, cdE[s] ? 16'h0278 : 16'h02E8);
        end
        st.compliantLock <= 1'b0;
        wr(12'h835, 16'h0004);
        settle();
        rc(12'h835, 16'h0004);
        st.compliantLock <= 1'b1;
        settle();
        rc(12'h835, 16'h0014);
        wr(12'h86C, 16'h0070);
        rc(12'h86C, 16'h0000);
        st.deviceLocked <= 1'b0;
        settle();
        rc(12'h86C, 16'h0040);
        st.deviceLocked <= 1'b1;
        st.digitalPhaseLocked <= 1'b0;
        settle();
        st.digitalPhaseLocked <= 1'b1;
        settle();
        rc(12'h86C, 16'h0060);
        wr(12'h86C, 16'h0040);
        rc(12'h86C, 16'h0020);
        finish_test();
    end
endmodule : testbench
